// ### core/wkt_pkg.sv
package wkt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register byte offsets
  localparam logic [7:0] TIMER_CONFIG_OFF = 8'h39;
  localparam logic [7:0] IRQ_A_ROUTE_UPPER_OFF = 8'h3a;
  localparam logic [7:0] IRQ_B_ROUTE_UPPER_OFF = 8'h3b;
  localparam logic [7:0] SECONDARY_FLAG_OFF = 8'h40;
  localparam logic [7:0] EVT_STATUS_OFF = 8'h41;
  localparam logic [7:0] EVT_CLEAR_OFF = 8'h42;
  localparam logic [7:0] EVT_ENABLE_OFF = 8'h43;

  // reset values and routing register write mask
  localparam logic [7:0] TIMER_CONFIG_RST = 8'h00;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [7:0] ROUTE_WR_MASK = 8'hdf;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // secondary flag register: heartbeat expiry bit
  localparam int HEARTBEAT_FLAG_BIT = 4;

  // interrupt status layout
  localparam int EVT_W = 2;
  localparam int EVT_WAKE_BIT = 0;
  localparam int EVT_HEARTBEAT_BIT = 1;

  // heartbeat selector limits
  localparam logic [4:0] HEARTBEAT_OFF_CODE = 5'h00;
  localparam logic [4:0] HEARTBEAT_MAX_CODE = 5'h14;
  localparam int HEARTBEAT_CNT_W = 21;

  // timing: one base tick is the shortest wake-up interval
  localparam int CLK_PERIOD_PS = 4000;
  localparam int WAKE_BASE_MS = 80;
  localparam longint WAKE_BASE_PS = longint'(WAKE_BASE_MS) * 1000000000;
  localparam int WAKE_BASE_CYCLES = int'(WAKE_BASE_PS / CLK_PERIOD_PS);
  localparam int WAKE_CNT_W = 4;

  typedef struct packed {
    logic [1:0] sample_interval_sel;
    logic spare;
    logic [4:0] heartbeat_sel;
  } wkt_timer_cfg_s;

  // event sources, laid out as the routing register bits
  typedef struct packed {
    logic trim_fault;
    logic config_fault;
    logic reserved;
    logic heartbeat;
    logic aux_high;
    logic aux_low;
    logic double_knock;
    logic single_knock;
  } wkt_irq_src_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } wkt_reg_req_s;

  typedef enum logic [1:0] {
    WKT_HB_OFF = 2'b01,
    WKT_HB_RUN = 2'b10
  } wkt_hb_state_e;

endpackage

// ### core/wkt_timer_irq.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE_01 - interval select gives 80/160/320/640 ms
// RULE_02 - heartbeat code zero disables the timer
// RULE_03 - codes 1..11 double from 160 ms
// RULE_04 - codes 12..20 keep doubling to 23.3 h
// RULE_05 - heartbeat expiry sets secondary flag bit 4
// RULE_06 - reading secondary flags clears expiry bit
// RULE_07 - expiry routable to either interrupt output
// RULE_08 - route bit 7 gates trim fault
// RULE_09 - route bit 6 gates config fault
// RULE_10 - route bit 4 gates heartbeat expiry
// RULE_11 - route bit 3 gates aux high event
// RULE_12 - route bit 2 gates aux low event
// RULE_13 - route bit 1 gates double knock
// RULE_14 - route bit 0 gates single knock
// RULE_15 - interrupt output ORs all routed sources
// RULE_16 - host writes codes up to 20 only
module wkt_timer_irq
  import wkt_pkg::*;
#(
  parameter int BASE_CYCLES = WAKE_BASE_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire wkt_reg_req_s req,
  output logic [DATA_W-1:0] rdata,
  input wire wkt_irq_src_s ext_events,
  output logic wake_sample,
  output logic irq_out_a,
  output logic irq_out_b,
  output logic irq_out
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  // wake period in base ticks: 1, 2, 4 or 8
  function automatic logic [WAKE_CNT_W-1:0] wake_last(input logic [1:0] s);
    wake_last = WAKE_CNT_W'((1 << s) - 1);
  endfunction

  // heartbeat period in base ticks: 2**code (code 1 = 160 ms)
  function automatic logic [HEARTBEAT_CNT_W-1:0] hb_last(
    input logic [4:0] c);
    hb_last = HEARTBEAT_CNT_W'((1 << c) - 1);
  endfunction

  wkt_timer_cfg_s timer_config;
  wkt_irq_src_s irq_a_route_upper;
  wkt_irq_src_s irq_b_route_upper;
  logic heartbeat_flag;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_enable;
  logic [31:0] base_cnt;
  logic [WAKE_CNT_W-1:0] wake_cnt;
  logic [HEARTBEAT_CNT_W-1:0] hb_cnt;
  wkt_hb_state_e hb_state;
  wkt_hb_state_e next_hb_state;

  // address decode
  wire wr_timer = req.wr && hit(req.addr, TIMER_CONFIG_OFF);
  wire wr_route_a = req.wr && hit(req.addr, IRQ_A_ROUTE_UPPER_OFF);
  wire wr_route_b = req.wr && hit(req.addr, IRQ_B_ROUTE_UPPER_OFF);
  wire wr_evt_clear = req.wr && hit(req.addr, EVT_CLEAR_OFF);
  wire wr_evt_enable = req.wr && hit(req.addr, EVT_ENABLE_OFF);
  wire rd_secondary = req.rd && hit(req.addr, SECONDARY_FLAG_OFF);

  // base tick prescaler
  wire base_tick = (base_cnt == 32'(BASE_CYCLES - 1));
  wire [31:0] next_base_cnt = (base_tick || wr_timer) ? 32'h0 :
                              base_cnt + 32'h1;

  // wake-up sample timer
  wire wake_hit = base_tick &&
    (wake_cnt == wake_last(timer_config.sample_interval_sel)); // RULE_01
  wire [WAKE_CNT_W-1:0] next_wake_cnt =
    (wr_timer || wake_hit) ? '0 :
    base_tick ? wake_cnt + WAKE_CNT_W'(1) : wake_cnt;

  // heartbeat timer
  wire [4:0] hb_code = timer_config.heartbeat_sel;
  wire hb_valid = (hb_code != HEARTBEAT_OFF_CODE) && // RULE_02
                  (hb_code <= HEARTBEAT_MAX_CODE); // RULE_16
  wire hb_expire = (hb_state == WKT_HB_RUN) && base_tick &&
                   (hb_cnt == hb_last(hb_code)); // RULE_03 RULE_04
  wire [HEARTBEAT_CNT_W-1:0] next_hb_cnt =
    (wr_timer || hb_expire || hb_state != WKT_HB_RUN) ? '0 :
    base_tick ? hb_cnt + HEARTBEAT_CNT_W'(1) : hb_cnt;

  always_comb
  begin
    next_hb_state = hb_state;
    case (hb_state)
      WKT_HB_OFF:
      begin
        if (hb_valid)
        begin
          next_hb_state = WKT_HB_RUN;
        end
      end
      WKT_HB_RUN:
      begin
        if (!hb_valid)
        begin
          next_hb_state = WKT_HB_OFF; // RULE_02
        end
      end
      default:
      begin
        next_hb_state = WKT_HB_OFF;
      end
    endcase
  end

  // secondary flag: set wins over the read clear
  wire next_heartbeat_flag = hb_expire ? 1'b1 : // RULE_05
                             rd_secondary ? 1'b0 : // RULE_06
                             heartbeat_flag;

  // interrupt status: events set, write-one clears, set wins
  wire [EVT_W-1:0] evt_set = {hb_expire, wake_hit};
  wire [EVT_W-1:0] evt_clr = wr_evt_clear ? req.wdata[EVT_W-1:0] : '0;
  wire [EVT_W-1:0] next_evt_status = evt_set | (evt_status & ~evt_clr);

  // routed interrupt sources
  wkt_irq_src_s src;
  always_comb
  begin
    src = ext_events;
    src.reserved = 1'b0;
    src.heartbeat = heartbeat_flag; // RULE_07
  end

  // RULE_08 RULE_09 RULE_10 RULE_11 RULE_12 RULE_13 RULE_14
  wire [DATA_W-1:0] routed_a = src & irq_a_route_upper;
  wire [DATA_W-1:0] routed_b = src & irq_b_route_upper;

  // read mux
  wire [DATA_W-1:0] secondary_val =
    DATA_W'({heartbeat_flag, {HEARTBEAT_FLAG_BIT{1'b0}}});
  logic [DATA_W-1:0] next_rdata;
  always_comb
  begin
    next_rdata = RDATA_RST;
    if (!req.rd)
    begin
      next_rdata = RDATA_RST;
    end
    else if (hit(req.addr, TIMER_CONFIG_OFF))
    begin
      next_rdata = timer_config;
    end
    else if (hit(req.addr, IRQ_A_ROUTE_UPPER_OFF))
    begin
      next_rdata = irq_a_route_upper;
    end
    else if (hit(req.addr, IRQ_B_ROUTE_UPPER_OFF))
    begin
      next_rdata = irq_b_route_upper;
    end
    else if (hit(req.addr, SECONDARY_FLAG_OFF))
    begin
      next_rdata = secondary_val;
    end
    else if (hit(req.addr, EVT_STATUS_OFF))
    begin
      next_rdata = DATA_W'(evt_status);
    end
    else if (hit(req.addr, EVT_ENABLE_OFF))
    begin
      next_rdata = DATA_W'(evt_enable);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      timer_config <= TIMER_CONFIG_RST;
    end
    else if (wr_timer)
    begin
      timer_config <= req.wdata;
    end
  end

  // routing registers; bit 5 is reserved and reads back 0
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_a_route_upper <= ROUTE_RST;
    end
    else if (wr_route_a)
    begin
      irq_a_route_upper <= req.wdata & ROUTE_WR_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_b_route_upper <= ROUTE_RST;
    end
    else if (wr_route_b)
    begin
      irq_b_route_upper <= req.wdata & ROUTE_WR_MASK;
    end
  end

  // base tick prescaler, restarted by any timer write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      base_cnt <= 32'h0;
    end
    else
    begin
      base_cnt <= next_base_cnt;
    end
  end

  // wake interval counter in base ticks
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wake_cnt <= '0;
    end
    else
    begin
      wake_cnt <= next_wake_cnt;
    end
  end

  // heartbeat interval counter in base ticks
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hb_cnt <= '0;
    end
    else
    begin
      hb_cnt <= next_hb_cnt;
    end
  end

  // heartbeat run state; one extra cycle to start after enabling
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hb_state <= WKT_HB_OFF;
    end
    else
    begin
      hb_state <= next_hb_state;
    end
  end

  // expiry flag, cleared by a read of the secondary flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      heartbeat_flag <= 1'b0;
    end
    else
    begin
      heartbeat_flag <= next_heartbeat_flag;
    end
  end

  // sticky interrupt status
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      evt_status <= '0;
    end
    else
    begin
      evt_status <= next_evt_status;
    end
  end

  // interrupt status enables
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      evt_enable <= '0;
    end
    else if (wr_evt_enable)
    begin
      evt_enable <= req.wdata[EVT_W-1:0];
    end
  end

  // read data stands for one cycle only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= RDATA_RST;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // one pulse per wake interval
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wake_sample <= 1'b0;
    end
    else
    begin
      wake_sample <= wake_hit;
    end
  end

  // registered so the interrupt pins never glitch
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_out_a <= 1'b0;
    end
    else
    begin
      irq_out_a <= |routed_a; // RULE_15
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_out_b <= 1'b0;
    end
    else
    begin
      irq_out_b <= |routed_b; // RULE_07
    end
  end

  // summary interrupt follows the status in the cycle it is set
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= |(next_evt_status & evt_enable);
    end
  end

endmodule

`default_nettype wire

// ### verification/wkt_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the register port: one-cycle strobes, changed after the edge
module wkt_host
  import wkt_pkg::*;
(
  input wire logic clk,
  input wire logic [DATA_W-1:0] rdata,
  output wkt_reg_req_s req
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask
endmodule
`default_nettype wire

// ### verification/wkt_timer_irq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module wkt_timer_irq_chk
  import wkt_pkg::*;
#(
  parameter int BASE_CYCLES = WAKE_BASE_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire wkt_reg_req_s req,
  input wire logic [DATA_W-1:0] rdata,
  input wire wkt_irq_src_s ext_events,
  input wire logic wake_sample,
  input wire logic irq_out_a,
  input wire logic irq_out_b,
  input wire logic irq_out
);
  logic [7:0] ra;
  logic [7:0] rb;
  int g;
  wire logic [7:0] lv = ext_events & 8'hcf;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shadow copies of the routing registers
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ra <= 8'h00;
    else if (req.wr && req.addr == IRQ_A_ROUTE_UPPER_OFF)
      ra <= req.wdata;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rb <= 8'h00;
    else if (req.wr && req.addr == IRQ_B_ROUTE_UPPER_OFF)
      rb <= req.wdata;
  // cycles since the last wake pulse; a pulse already launched when the
  // timer restarts may still come, so a restart does not reset the count
  always_ff @(posedge clk or posedge rst)
    if (rst)
      g <= 0;
    else if (wake_sample)
      g <= 0;
    else
      g <= g + 1;
  chk_rd_window: assert property (rdata != 8'h00 |-> $past(req.rd))
    else $error("read data outside its cycle");
  chk_wake_pulse: assert property (wake_sample |=> !wake_sample)
    else $error("wake pulse too long");
  chk_wake_gap: assert property (wake_sample |-> g >= BASE_CYCLES - 1)
    else $error("wake pulses too close");
  chk_trim_gate: assert property (ext_events.trim_fault && ra[7] |=> irq_out_a)
    else $error("trim fault not routed");
  chk_cfg_gate: assert property (ext_events.config_fault && ra[6] |=> irq_out_a)
    else $error("config fault not routed");
  chk_aux_gate: assert property ((lv[3] && ra[3]) || (lv[2] && ra[2]) |=> irq_out_a)
    else $error("aux event not routed");
  chk_knock_gate: assert property ((lv[1] && ra[1]) || (lv[0] && ra[0]) |=> irq_out_a)
    else $error("knock event not routed");
  chk_quiet_a: assert property (!ra[4] && (lv & ra) == 8'h00 |=> !irq_out_a)
    else $error("output a high without source");
  chk_route_b: assert property ((lv & rb) != 8'h00 |=> irq_out_b)
    else $error("output b missed source");
  chk_quiet_b: assert property (!rb[4] && (lv & rb) == 8'h00 |=> !irq_out_b)
    else $error("output b high without source");
endmodule
bind wkt_timer_irq wkt_timer_irq_chk #(.BASE_CYCLES(BASE_CYCLES)) chk_u (.clk,
  .rst, .req, .rdata, .ext_events, .wake_sample, .irq_out_a, .irq_out_b,
  .irq_out);
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wkt_pkg::*;
  localparam int B = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wkt_reg_req_s req;
  wkt_irq_src_s ext_events = '0;
  logic [7:0] rdata, d, ra, rb;
  logic wake_sample, irq_out_a, irq_out_b, irq_out;
  int fail_count = 0;
  int n_compared = 0;
  int seed = 62829;
  int cyc = 0;
  int t0;
  int hb[4] = '{1, 2, 3, 12};
  int off[2] = '{0, 21};
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  wkt_timer_irq #(.BASE_CYCLES(B)) dut_u (.clk, .rst, .req, .rdata,
    .ext_events, .wake_sample, .irq_out_a, .irq_out_b, .irq_out);
  wkt_host host_u (.clk, .rdata, .req);
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic ok);
    n_compared++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("BAD %0t mismatch at check %0d", $time, n_compared);
    end
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk(d === e);
  endtask
  task upto(input int w, input logic v);
    logic s;
    for (int n = 0; n < 20000; n++)
    begin
      @(negedge clk);
      s = w == 0 ? wake_sample : w == 1 ? irq_out_a : irq_out;
      if (s === v)
        return;
    end
    chk(1'b0);
    stop_test;
  endtask
  // rise-to-rise spacing; for irq_out_a the heartbeat flag is read away in between
  task gap(input int w, input int p);
    upto(w, 1'b0);
    upto(w, 1'b1);
    t0 = cyc;
    if (w == 1)
      rc(8'h40, 8'h10);
    upto(w, 1'b0);
    upto(w, 1'b1);
    chk(cyc - t0 == p);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc(8'h39, 8'h00);
    rc(8'h3a, 8'h00);
    host_u.wr(8'h3a, 8'hff);
    rc(8'h3a, 8'hdf);
    host_u.wr(8'h39, 8'hff);
    rc(8'h39, 8'hff);
    host_u.wr(8'h50, 8'hff);
    rc(8'h50, 8'h00);
    $display("end registers");
    for (int s = 0; s < 4; s++)
    begin
      host_u.wr(8'h39, 8'(s << 6));
      gap(0, B << s);
    end
    $display("end wake");
    host_u.wr(8'h43, 8'h01);
    upto(2, 1'b1);
    rc(8'h41, 8'h01);
    host_u.wr(8'h43, 8'h00);
    repeat (2) @(negedge clk);
    chk(irq_out === 1'b0);
    host_u.wr(8'h39, 8'hc0);
    host_u.wr(8'h42, 8'h01);
    host_u.wr(8'h43, 8'h01);
    repeat (2) @(negedge clk);
    chk(irq_out === 1'b0);
    rc(8'h41, 8'h00);
    $display("end interrupt");
    host_u.wr(8'h3a, 8'h10);
    foreach (hb[i])
    begin
      host_u.wr(8'h39, 8'(hb[i]));
      gap(1, B << hb[i]);
      rc(8'h40, 8'h10);
    end
    rc(8'h40, 8'h00);
    foreach (off[i])
    begin
      host_u.wr(8'h39, 8'(off[i]));
      repeat (300) @(negedge clk);
      rc(8'h40, 8'h00);
    end
    $display("end heartbeat");
    for (int i = 0; i < 48; i++)
    begin
      if (i % 8 == 0)
      begin
        ra = 8'($random(seed));
        rb = 8'($random(seed));
        host_u.wr(8'h3a, ra);
        host_u.wr(8'h3b, rb);
      end
      @(posedge clk);
      ext_events <= 8'($random(seed));
      @(posedge clk);
      #1 chk(irq_out_a === |(ext_events & ra & 8'hcf));
      chk(irq_out_b === |(ext_events & rb & 8'hcf));
    end
    $display("end routing");
    stop_test;
  end
endmodule
`default_nettype wire
